// [src/usart_ctrl.sv]
// Serial transceiver: control/status registers, baud generator, shifters.
// Assumes a classic Wishbone master and an external tri-state pad pair.
//
// Behaviour
// - Pins serve the port only with port enabled and both directions input.
// - Synchronous: clock source one is master on generator clock, zero slave.
// - Transmit width bit picks nine-bit or eight-bit characters.
// - Transmit enable starts sending; synchronous receive enables override it.
// - Mode bit selects synchronous when set, asynchronous when clear.
// - Bit three of both control registers reads zero.
// - Asynchronous speed bit picks divide by 16 or 64; ignored synchronously.
// - Shifter empty flag reads one while idle, zero while busy; resets one.
// - Transmit ninth bit supplies the ninth data bit in nine-bit mode.
// - Port enable turns the whole serial port on or off.
// - Receive width bit picks nine-bit or eight-bit reception.
// - Single receive takes one character as master, then clears itself.
// - Continuous receive runs while set and overrides single receive.
// - Framing error flag updates as each received byte is stored.
// - Overrun flag sets on a lost byte, clears when continuous clears.
// - Receive ninth bit shows ninth received bit; unknown after reset.
// - Baud generator is a free-running eight-bit timer set by divisor.
// - Asynchronous rate is clock over 64 or 16 times divisor plus one.
// - Synchronous rate is clock over 4 times divisor plus one.
// - Synchronous rate formula applies to master only; slave follows external clock.
// - Writing the divisor restarts the baud timer at once.
// - Divisor accepts every value from 0 to 255.
`timescale 1ns/1ns
module usart_ctrl (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire usart_pkg::wb_req_s wb_i,
  output logic wb_ack_o,
  output logic [31:0] wb_dat_o,
  input wire logic txck_pin_i,
  output logic txck_pin_o,
  output logic txck_pin_oe_o,
  input wire logic rxdt_pin_i,
  output logic rxdt_pin_o,
  output logic rxdt_pin_oe_o
);
  import usart_pkg::*;

  function automatic logic is_reg(input logic [7:0] adr,
                                  input logic [7:0] off);
    is_reg = (adr[7:2] == off[7:2]);
  endfunction : is_reg

  function automatic logic [3:0] frame_last(input logic sync,
                                            input logic nine);
    if (sync)
    begin
      frame_last = nine ? FRAME_SYNC9_M1 : FRAME_SYNC8_M1;
    end
    else
    begin
      frame_last = nine ? FRAME_ASYNC9_M1 : FRAME_ASYNC8_M1;
    end
  endfunction : frame_last

  // Registers
  logic ack_ff;
  logic [31:0] rdat_ff;
  tx_ctrl_s txc_ff;
  rx_ctrl_s rxc_ff;
  logic [7:0] div_ff;
  logic [1:0] pin_dir_ff;
  logic [7:0] brg_cnt_ff;
  logic [5:0] phase_ff;
  logic [5:0] rx_phase_ff;
  logic [1:0] s1_ff;
  logic [1:0] s2_ff;
  logic [1:0] s3_ff;
  logic [1:0] pin_ff;
  logic ck_prev_ff;
  tx_state_e tx_st_ff;
  logic [10:0] tx_sh_ff;
  logic [3:0] tx_cnt_ff;
  logic [7:0] tx_hold_ff;
  logic tx_full_ff;
  rx_state_e rx_st_ff;
  logic [8:0] rx_sh_ff;
  logic [3:0] rx_cnt_ff;
  logic [7:0] rx_data_ff;
  logic rx_ninth_ff;
  logic rx_full_ff;
  logic framing_error_flag_ff;
  logic overrun_error_flag_ff;
  logic txck_o_ff;
  logic txck_oe_ff;
  logic rxdt_o_ff;
  logic rxdt_oe_ff;

  // Bus decode
  logic bus_req;
  logic bus_wr;
  logic rd_rxd;
  logic [7:0] wdat8;
  logic wr_txc;
  logic wr_rxc;
  logic wr_div;
  logic wr_txd;
  logic wr_dir;
  logic [7:0] rd_mux;
  logic [7:0] txc_rd;
  logic [7:0] rxc_rd;

  assign bus_req = wb_i.cyc & wb_i.stb;
  assign bus_wr = bus_req & ack_ff & wb_i.we & wb_i.sel[0];
  assign rd_rxd = bus_req & ack_ff & ~wb_i.we & is_reg(wb_i.adr, OFF_RX_DATA);
  assign wdat8 = wb_i.dat[7:0];
  assign wr_txc = bus_wr & is_reg(wb_i.adr, OFF_TX_CTRL);
  assign wr_rxc = bus_wr & is_reg(wb_i.adr, OFF_RX_CTRL);
  assign wr_div = bus_wr & is_reg(wb_i.adr, OFF_BAUD_DIV);
  assign wr_txd = bus_wr & is_reg(wb_i.adr, OFF_TX_DATA);
  assign wr_dir = bus_wr & is_reg(wb_i.adr, OFF_PIN_DIR);

  // Mode decode
  logic port_on;
  logic sync_on;
  logic master;
  logic [5:0] presc_m1;
  logic [5:0] half_m1;
  logic brg_tick;
  logic bit_end;
  logic phase_clr;
  logic ck_in;
  logic line_in;
  logic ck_rise;
  logic ck_fall;

  assign port_on = rxc_ff.port_enable & (pin_dir_ff == 2'h3);
  assign sync_on = txc_ff.sync_mode;
  assign master = sync_on & txc_ff.clock_source_select;
  assign presc_m1 = sync_on ? PRESC_SYNC_M1 :
                    (txc_ff.high_speed_select ? PRESC_HIGH_M1 : PRESC_LOW_M1);
  assign half_m1 = txc_ff.high_speed_select ? HALF_HIGH_M1 : HALF_LOW_M1;

  // Baud generator
  // tick on wrap
  assign brg_tick = (brg_cnt_ff == 8'h00);

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      brg_cnt_ff <= 8'h00;
    end
    else if (wr_div)
    begin
      brg_cnt_ff <= wdat8;
    end
    // free-running reload
    // Frame start realigns so the first bit is full length
    else if (brg_tick || phase_clr)
    begin
      brg_cnt_ff <= div_ff;
    end
    else
    begin
      brg_cnt_ff <= brg_cnt_ff - 8'h01;
    end
  end

  // Bit timer shared by transmitter and synchronous master
  assign bit_end = brg_tick & (phase_ff == presc_m1);

  always_ff @(posedge clk_i)
  begin
    if (rst_i || phase_clr)
    begin
      phase_ff <= 6'h00;
    end
    else if (brg_tick)
    begin
      phase_ff <= (phase_ff == presc_m1) ? 6'h00 : phase_ff + 6'h01;
    end
  end

  // Pin synchronisers; a change counts once stages two and three agree
  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++)
    begin : g_sync
      always_ff @(posedge clk_i)
      begin
        if (rst_i)
        begin
          s1_ff[gi] <= 1'b1;
          s2_ff[gi] <= 1'b1;
          s3_ff[gi] <= 1'b1;
          pin_ff[gi] <= 1'b1;
        end
        else
        begin
          s1_ff[gi] <= gi == 0 ? txck_pin_i : rxdt_pin_i;
          s2_ff[gi] <= s1_ff[gi];
          s3_ff[gi] <= s2_ff[gi];
          pin_ff[gi] <= (s2_ff[gi] == s3_ff[gi]) ? s3_ff[gi] : pin_ff[gi];
        end
      end
    end
  endgenerate
  assign ck_in = pin_ff[0];
  assign line_in = pin_ff[1];
  assign ck_rise = ck_in & ~ck_prev_ff;
  assign ck_fall = ~ck_in & ck_prev_ff;

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ck_prev_ff <= 1'b1;
    end
    else
    begin
      ck_prev_ff <= ck_in;
    end
  end

  // Transmitter
  logic rx_req;
  logic tx_allow;
  logic tx_load;
  logic tx_shift;
  logic tx_busy;
  logic [10:0] tx_frame;

  assign rx_req = rxc_ff.single_receive_enable |
                  rxc_ff.continuous_receive_enable;
  assign tx_allow = txc_ff.tx_enable & port_on & ~(sync_on & rx_req);
  assign tx_load = (tx_st_ff == TX_IDLE) & tx_full_ff & tx_allow;
  assign tx_shift = master | ~sync_on ? bit_end : ck_fall;
  assign tx_busy = (tx_st_ff == TX_SHIFT);
  assign tx_frame = sync_on ?
    {2'h3, txc_ff.tx_ninth_bit, tx_hold_ff} :
    {1'b1, txc_ff.tx_nine_bit_select ? txc_ff.tx_ninth_bit : 1'b1,
     tx_hold_ff, 1'b0};

  always_ff @(posedge clk_i)
  begin
    if (rst_i || !tx_allow)
    begin
      tx_st_ff <= TX_IDLE;
      tx_sh_ff <= 11'h7FF;
      tx_cnt_ff <= 4'h0;
    end
    else if (tx_load)
    begin
      tx_st_ff <= TX_SHIFT;
      tx_sh_ff <= tx_frame;
      tx_cnt_ff <= frame_last(sync_on, txc_ff.tx_nine_bit_select);
    end
    else if (tx_busy && tx_shift)
    begin
      tx_st_ff <= (tx_cnt_ff == 4'h0) ? TX_IDLE : TX_SHIFT;
      tx_sh_ff <= {1'b1, tx_sh_ff[10:1]};
      tx_cnt_ff <= tx_cnt_ff - 4'h1;
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      tx_full_ff <= 1'b0;
      tx_hold_ff <= 8'h00;
    end
    else
    begin
      tx_full_ff <= wr_txd | (tx_full_ff & ~tx_load);
      tx_hold_ff <= wr_txd ? wdat8 : tx_hold_ff;
    end
  end

  // Receiver
  logic rx_en;
  logic rx_start;
  logic rx_samp;
  logic rx_busy;
  logic rx_first;
  logic rx_done;
  logic rx_accept;
  logic rx_lost;
  logic [3:0] rx_last;
  logic [8:0] rx_sh_nxt;
  logic [8:0] rx_cap;

  assign rx_en = port_on & ~overrun_error_flag_ff & (master ? rx_req :
                 rxc_ff.continuous_receive_enable);
  assign rx_busy = (rx_st_ff == RX_SHIFT);
  assign rx_start = (rx_st_ff == RX_IDLE) & rx_en & (sync_on | ~line_in);
  assign rx_last = frame_last(sync_on, rxc_ff.rx_nine_bit_select);
  assign rx_first = (rx_cnt_ff == rx_last);
  assign rx_samp = ~sync_on ?
    brg_tick & (rx_phase_ff == half_m1) :
    (master ? brg_tick & (phase_ff == SYNC_SAMPLE_PHASE) : ck_rise);
  assign rx_done = rx_busy & rx_samp & (rx_cnt_ff == 4'h0);
  assign rx_accept = rx_done & (~rx_full_ff | rd_rxd);
  assign rx_lost = rx_done & rx_full_ff & ~rd_rxd;
  assign rx_sh_nxt = {line_in, rx_sh_ff[8:1]};
  assign rx_cap = sync_on ? rx_sh_nxt : rx_sh_ff;
  assign phase_clr = wr_div | tx_load | (rx_start & master);

  always_ff @(posedge clk_i)
  begin
    if (rst_i || wr_div || rx_start)
    begin
      rx_phase_ff <= 6'h00;
    end
    else if (brg_tick)
    begin
      rx_phase_ff <= (rx_phase_ff == presc_m1) ? 6'h00 : rx_phase_ff + 6'h01;
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i || !rx_en)
    begin
      rx_st_ff <= RX_IDLE;
      rx_cnt_ff <= 4'h0;
      rx_sh_ff <= 9'h000;
    end
    else if (rx_start)
    begin
      rx_st_ff <= RX_SHIFT;
      rx_cnt_ff <= rx_last;
    end
    else if (rx_busy && rx_samp)
    begin
      // False start bit drops back to idle
      if ((rx_cnt_ff == 4'h0) || (!sync_on && rx_first && line_in))
      begin
        rx_st_ff <= RX_IDLE;
      end
      if (sync_on || (!rx_first && rx_cnt_ff != 4'h0))
      begin
        rx_sh_ff <= rx_sh_nxt;
      end
      rx_cnt_ff <= rx_cnt_ff - 4'h1;
    end
  end

  // Received character store; a read in the same cycle frees the slot
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      rx_full_ff <= 1'b0;
      rx_data_ff <= 8'h00;
      framing_error_flag_ff <= 1'b0;
    end
    else
    begin
      rx_full_ff <= rx_accept | (rx_full_ff & ~rd_rxd);
      if (rx_accept)
      begin
        rx_data_ff <= rxc_ff.rx_nine_bit_select ? rx_cap[7:0] : rx_cap[8:1];
        framing_error_flag_ff <= ~sync_on & ~line_in;
      end
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rx_accept)
    begin
      rx_ninth_ff <= rx_cap[8];
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      overrun_error_flag_ff <= 1'b0;
    end
    else
    begin
      overrun_error_flag_ff <= rx_lost | (overrun_error_flag_ff & ~(wr_rxc & ~wdat8[4]));
    end
  end

  // Control registers
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      txc_ff <= tx_ctrl_s'(TX_CTRL_RST & TX_CTRL_WMASK);
      rxc_ff <= rx_ctrl_s'(RX_CTRL_RST);
      div_ff <= BAUD_DIV_RST;
      pin_dir_ff <= PIN_DIR_RST;
    end
    else
    begin
      if (wr_txc)
      begin
        txc_ff <= tx_ctrl_s'(wdat8 & TX_CTRL_WMASK);
      end
      if (wr_rxc)
      begin
        rxc_ff <= rx_ctrl_s'(wdat8 & RX_CTRL_WMASK);
      end
      else if (rx_done && master && !rxc_ff.continuous_receive_enable)
      begin
        rxc_ff.single_receive_enable <= 1'b0;
      end
      if (wr_div)
      begin
        div_ff <= wdat8;
      end
      if (wr_dir)
      begin
        pin_dir_ff <= wdat8[PIN_DIR_LSB +: 2];
      end
    end
  end

  // Read mux
  // bit three reads zero
  assign txc_rd = {txc_ff.clock_source_select, txc_ff.tx_nine_bit_select,
                   txc_ff.tx_enable, txc_ff.sync_mode, 1'b0,
                   txc_ff.high_speed_select, ~tx_busy, txc_ff.tx_ninth_bit};
  assign rxc_rd = {rxc_ff.port_enable, rxc_ff.rx_nine_bit_select,
                   rxc_ff.single_receive_enable,
                   rxc_ff.continuous_receive_enable, 1'b0,
                   framing_error_flag_ff, overrun_error_flag_ff, rx_ninth_ff};
  assign rd_mux =
    is_reg(wb_i.adr, OFF_TX_CTRL) ? txc_rd :
    is_reg(wb_i.adr, OFF_RX_CTRL) ? rxc_rd :
    is_reg(wb_i.adr, OFF_RX_DATA) ? rx_data_ff :
    is_reg(wb_i.adr, OFF_BAUD_DIV) ? div_ff :
    is_reg(wb_i.adr, OFF_PIN_DIR) ? {pin_dir_ff, 6'h00} :
    is_reg(wb_i.adr, OFF_STATUS) ? {6'h00, rx_full_ff, tx_full_ff} :
    8'h00;

  // Wishbone slave: ack one cycle after request, for one cycle
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ack_ff <= 1'b0;
      rdat_ff <= 32'h0000_0000;
    end
    else
    begin
      ack_ff <= bus_req & ~ack_ff;
      if (bus_req && !ack_ff)
      begin
        rdat_ff <= {24'h00_0000, rd_mux};
      end
    end
  end

  // Pin drivers, registered
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      txck_o_ff <= 1'b1;
      txck_oe_ff <= 1'b0;
      rxdt_o_ff <= 1'b1;
      rxdt_oe_ff <= 1'b0;
    end
    else
    begin
      txck_o_ff <= sync_on ?
        (master & (tx_busy | rx_busy) & phase_ff[1]) : tx_sh_ff[0];
      txck_oe_ff <= port_on & (~sync_on | master);
      rxdt_o_ff <= tx_sh_ff[0];
      rxdt_oe_ff <= port_on & sync_on & tx_busy;
    end
  end

  assign wb_ack_o = ack_ff;
  assign wb_dat_o = rdat_ff;
  assign txck_pin_o = txck_o_ff;
  assign txck_pin_oe_o = txck_oe_ff;
  assign rxdt_pin_o = rxdt_o_ff;
  assign rxdt_pin_oe_o = rxdt_oe_ff;

endmodule : usart_ctrl

// [src/usart_pkg.sv]
// Constants, register map and carrier types of the serial transceiver.
// Assumes a 50 MHz system clock and a classic Wishbone register bus.
package usart_pkg;

  // Register byte offsets
  localparam logic [7:0] OFF_RX_CTRL = 8'h18;
  localparam logic [7:0] OFF_RX_DATA = 8'h1C;
  localparam logic [7:0] OFF_TX_DATA = 8'h94;
  localparam logic [7:0] OFF_TX_CTRL = 8'h98;
  localparam logic [7:0] OFF_BAUD_DIV = 8'h9C;
  localparam logic [7:0] OFF_PIN_DIR = 8'hA0;
  localparam logic [7:0] OFF_STATUS = 8'hA4;

  // Reset values and writable-bit masks
  localparam logic [7:0] TX_CTRL_RST = 8'h02;
  localparam logic [7:0] RX_CTRL_RST = 8'h00;
  localparam logic [7:0] BAUD_DIV_RST = 8'h00;
  localparam logic [1:0] PIN_DIR_RST = 2'h3;
  localparam logic [7:0] TX_CTRL_WMASK = 8'hF5;
  localparam logic [7:0] RX_CTRL_WMASK = 8'hF0;
  localparam int PIN_DIR_LSB = 6;

  // Bit-timer prescale, last phase of a bit and mid-bit sample phase
  localparam logic [5:0] PRESC_LOW_M1 = 6'h3F;
  localparam logic [5:0] PRESC_HIGH_M1 = 6'h0F;
  localparam logic [5:0] PRESC_SYNC_M1 = 6'h03;
  localparam logic [5:0] HALF_LOW_M1 = 6'h1F;
  localparam logic [5:0] HALF_HIGH_M1 = 6'h07;
  localparam logic [5:0] SYNC_SAMPLE_PHASE = 6'h02;

  // Last bit index of a frame
  localparam logic [3:0] FRAME_SYNC8_M1 = 4'h7;
  localparam logic [3:0] FRAME_SYNC9_M1 = 4'h8;
  localparam logic [3:0] FRAME_ASYNC8_M1 = 4'h9;
  localparam logic [3:0] FRAME_ASYNC9_M1 = 4'hA;

  typedef struct packed {
    logic clock_source_select;
    logic tx_nine_bit_select;
    logic tx_enable;
    logic sync_mode;
    logic unused3;
    logic high_speed_select;
    logic shifter_empty_flag;
    logic tx_ninth_bit;
  } tx_ctrl_s;

  typedef struct packed {
    logic port_enable;
    logic rx_nine_bit_select;
    logic single_receive_enable;
    logic continuous_receive_enable;
    logic unused3;
    logic framing_error_flag;
    logic overrun_error_flag;
    logic rx_ninth_bit;
  } rx_ctrl_s;

  typedef struct packed {
    logic cyc;
    logic stb;
    logic we;
    logic [7:0] adr;
    logic [3:0] sel;
    logic [31:0] dat;
  } wb_req_s;

  typedef enum logic {TX_IDLE, TX_SHIFT} tx_state_e;
  typedef enum logic {RX_IDLE, RX_SHIFT} rx_state_e;

endpackage : usart_pkg

// [verification/testbench.sv]
// Self-checking bench for usart_ctrl with a far-side serial peer.
// Assumes usart_partner and the bound checker are compiled alongside.
`timescale 1ns/1ns
module testbench;
  import usart_pkg::*;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  wb_req_s wb_req = '0;
  logic wb_ack_o, txck_pin_i, txck_pin_o, txck_pin_oe_o;
  logic rxdt_pin_i, rxdt_pin_o, rxdt_pin_oe_o;
  logic [31:0] wb_dat_o;
  int mismatches = 0;
  int tests_run = 0;
  int cycles = 0;
  int seed = 50309;
  always #10 clk_i = ~clk_i;
  usart_ctrl u_dut (.clk_i, .rst_i, .wb_i(wb_req), .wb_ack_o, .wb_dat_o,
    .txck_pin_i, .txck_pin_o, .txck_pin_oe_o, .rxdt_pin_i, .rxdt_pin_o,
    .rxdt_pin_oe_o);
  usart_partner u_far (.clk_i, .txck_pin_o, .txck_pin_oe_o, .rxdt_pin_o,
    .rxdt_pin_oe_o, .txck_pin_i, .rxdt_pin_i);
  task automatic conclude();
    $display("mismatches %0d tests_run %0d", mismatches, tests_run);
    if (mismatches == 0 && tests_run > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : conclude
  always @(posedge clk_i)
  begin
    cycles++;
    if (cycles == 40000)
    begin
      mismatches++;
      conclude();
    end
  end
  task automatic chk(input logic [9:0] g, input logic [9:0] e,
    input string s);
    tests_run++;
    if (g !== e)
    begin
      mismatches++;
      $display("CHECK FAILED %0t %s got %h exp %h", $time, s, g, e);
    end
  endtask : chk
  task automatic chn(input int g, input int e, input string s);
    tests_run++;
    if (g != e)
    begin
      mismatches++;
      $display("CHECK FAILED %0t %s got %0d exp %0d", $time, s, g, e);
    end
  endtask : chn
  function automatic int bitc(input logic sy, input logic h, input int d);
    return (sy ? 4 : (h ? 16 : 64)) * (d + 1);
  endfunction : bitc
  function automatic logic [9:0] fexp(input logic n9, input logic t,
    input logic [7:0] b);
    return n9 ? {1'b1, t, b} : {2'b01, b};
  endfunction : fexp
  task automatic wb(input logic w, input logic [7:0] a, input logic [7:0] d,
    output logic [7:0] q);
    int n;
    n = 0;
    wb_req <= '{1'b1, 1'b1, w, a, 4'h1, {24'h0, d}};
    do @(posedge clk_i) n++; while (wb_ack_o !== 1'b1 && n < 50);
    q = wb_dat_o[7:0];
    wb_req <= '0;
    @(posedge clk_i);
    if (n >= 50)
      mismatches++;
  endtask : wb
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [7:0] q;
    wb(1'b1, a, d, q);
  endtask : wr
  task automatic rdc(input logic [7:0] a, input logic [7:0] e,
    input logic [7:0] m, input string s);
    logic [7:0] q;
    wb(1'b0, a, 8'h00, q);
    chk({2'b00, q & m}, {2'b00, e & m}, s);
  endtask : rdc
  task automatic ready();
    logic [7:0] q;
    int n;
    n = 0;
    do
    begin
      wb(1'b0, OFF_STATUS, 8'h00, q);
      n++;
    end
    while (q[1] !== 1'b1 && n < 60);
    chk({9'h0, q[1]}, 10'h001, "rx ready");
  endtask : ready
  initial
  begin
    logic [7:0] b;
    logic [9:0] v;
    logic t9;
    logic hs;
    logic n9;
    int lo;
    int d;
    repeat (12) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    rdc(OFF_TX_CTRL, 8'h02, 8'hFF, "txc");
    rdc(OFF_RX_CTRL, 8'h00, 8'hFE, "rxc");
    rdc(OFF_BAUD_DIV, 8'h00, 8'hFF, "div");
    rdc(OFF_PIN_DIR, 8'hC0, 8'hFF, "dir");
    rdc(8'hF0, 8'h00, 8'hFF, "unmapped");
    wr(OFF_PIN_DIR, 8'h00);
    wr(OFF_TX_CTRL, 8'hFF);
    wr(OFF_RX_CTRL, 8'hFF);
    rdc(OFF_TX_CTRL, 8'hF7, 8'hFF, "txc wr");
    rdc(OFF_RX_CTRL, 8'hF0, 8'hFE, "rxc wr");
    wr(OFF_TX_CTRL, 8'h00);
    wr(OFF_RX_CTRL, 8'h00);
    wr(OFF_PIN_DIR, 8'hC0);
    for (int i = 0; i < 6; i++)
    begin
      b = (i == 0) ? 8'h00 : ((i == 1) ? 8'hFF : 8'($random(seed)));
      wr(OFF_BAUD_DIV, b);
      rdc(OFF_BAUD_DIV, b, 8'hFF, "div");
    end
    wr(OFF_RX_CTRL, 8'h80);
    for (int i = 0; i < 5; i++)
    begin
      hs = 1'(i);
      d = i % 3;
      n9 = (i == 4);
      t9 = 1'($random(seed));
      b = 8'($random(seed)) | 8'h01;
      wr(OFF_BAUD_DIV, 8'(d));
      wr(OFF_TX_CTRL, {1'b0, n9, 3'b100, hs, 1'b0, t9});
      fork
        u_far.aget(n9 ? 9 : 8, bitc(1'b0, hs, d), v, lo);
        begin
          wr(OFF_TX_DATA, b);
          rdc(OFF_TX_CTRL, 8'h00, 8'h02, "busy");
        end
      join
      chk(v, fexp(n9, t9, b), "async frame");
      chn(lo, bitc(1'b0, hs, d), "async bit");
      rdc(OFF_TX_CTRL, 8'h02, 8'h02, "empty");
    end
    wr(OFF_TX_CTRL, 8'h04);
    wr(OFF_BAUD_DIV, 8'h00);
    for (int i = 0; i < 3; i++)
    begin
      b = 8'($random(seed));
      wr(OFF_RX_CTRL, (i == 1) ? 8'hD0 : 8'h90);
      u_far.send({1'b1, b}, (i == 1) ? 9 : 8, 16, i != 2);
      ready();
      rdc(OFF_RX_CTRL, {5'h0, i == 2, 2'b01}, 8'h06 | 8'(i == 1), "rxf");
      rdc(OFF_RX_DATA, b, 8'hFF, "rx data");
    end
    u_far.send(9'h1A5, 8, 16, 1'b1);
    u_far.send(9'h15A, 8, 16, 1'b1);
    ready();
    rdc(OFF_RX_CTRL, 8'h02, 8'h02, "overrun_error_flag");
    wr(OFF_RX_CTRL, 8'h80);
    rdc(OFF_RX_CTRL, 8'h00, 8'h02, "overrun_error_flag clr");
    rdc(OFF_RX_DATA, 8'hA5, 8'hFF, "kept");
    for (int i = 0; i < 2; i++)
    begin
      d = $random(seed) & 3;
      b = 8'($random(seed));
      wr(OFF_BAUD_DIV, 8'(d));
      wr(OFF_TX_CTRL, {5'b10110, 1'(i), 2'b00});
      fork
        u_far.sget(lo, v);
        wr(OFF_TX_DATA, b);
      join
      chk(v, {2'b00, b}, "sync frame");
      chn(lo, bitc(1'b1, 1'(i), d), "sync bit");
      repeat (bitc(1'b1, 1'b0, d)) @(posedge clk_i);
      rdc(OFF_TX_CTRL, 8'h02, 8'h02, "empty");
    end
    d = 3;
    wr(OFF_BAUD_DIV, 8'h03);
    wr(OFF_TX_CTRL, 8'hB0);
    wr(OFF_RX_CTRL, 8'h90);
    wr(OFF_TX_DATA, 8'h3C);
    repeat (40) @(posedge clk_i);
    @(negedge clk_i);
    chk({9'h0, rxdt_pin_oe_o}, 10'h000, "rx wins");
    @(posedge clk_i);
    rdc(OFF_TX_CTRL, 8'h02, 8'h02, "held");
    wr(OFF_RX_CTRL, 8'h80);
    u_far.sget(lo, v);
    chk(v, 10'h03C, "tx after");
    repeat (bitc(1'b1, 1'b0, d)) @(posedge clk_i);
    wb(1'b0, OFF_RX_DATA, 8'h00, b);
    wr(OFF_TX_CTRL, 8'h90);
    wr(OFF_RX_CTRL, 8'hA0);
    ready();
    rdc(OFF_RX_CTRL, 8'h80, 8'hF0, "single");
    rdc(OFF_RX_DATA, 8'hFF, 8'hFF, "single");
    conclude();
  end
endmodule : testbench

// [verification/usart_ctrl_properties.sv]
// Checker of usart_ctrl bus and pad behaviour, from its ports only.
// Assumes a classic Wishbone master; bound at the foot of this file.
`timescale 1ns/1ns
module usart_ctrl_properties
  import usart_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire usart_pkg::wb_req_s wb_i,
  input wire logic wb_ack_o,
  input wire logic [31:0] wb_dat_o,
  input wire logic txck_pin_i,
  input wire logic txck_pin_o,
  input wire logic txck_pin_oe_o,
  input wire logic rxdt_pin_i,
  input wire logic rxdt_pin_o,
  input wire logic rxdt_pin_oe_o
);
  logic pe_ff;
  logic [1:0] dir_ff;
  wire req = wb_i.cyc & wb_i.stb;
  wire wr0 = req & wb_i.we & wb_i.sel[0] & wb_ack_o;
  wire rd = req & ~wb_i.we & wb_ack_o;
  wire [5:0] wa = wb_i.adr[7:2];
  wire on = pe_ff & (dir_ff == 2'h3);
  // Port state as software last wrote it
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      pe_ff <= 1'b0;
      dir_ff <= 2'h3;
    end
    else
    begin
      if (wr0 && wa == OFF_RX_CTRL[7:2])
        pe_ff <= wb_i.dat[7];
      if (wr0 && wa == OFF_PIN_DIR[7:2])
        dir_ff <= wb_i.dat[7:6];
    end
  end
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held");
  a_ack_latency: assert property (req && !wb_ack_o |=> wb_ack_o)
    else $error("ack late");
  a_read_upper: assert property (rd |-> wb_dat_o[31:8] == 24'h0)
    else $error("upper read bits set");
  a_bit3_zero: assert property (rd && (wa == OFF_TX_CTRL[7:2] ||
    wa == OFF_RX_CTRL[7:2]) |-> !wb_dat_o[3]) else $error("bit 3 set");
  a_txdata_zero: assert property (rd && wa == OFF_TX_DATA[7:2]
    |-> wb_dat_o == 32'h0) else $error("tx data readable");
  a_unmapped_zero: assert property (rd && wb_i.adr[7:4] == 4'hF
    |-> wb_dat_o == 32'h0) else $error("unmapped read data");
  a_port_quiet: assert property (!on |=>
    !txck_pin_oe_o && !rxdt_pin_oe_o) else $error("pad driven when off");
  a_reset_idle: assert property (disable iff (1'b0) rst_i
    |=> !wb_ack_o && txck_pin_o && !txck_pin_oe_o && !rxdt_pin_oe_o)
    else $error("not idle in reset");
endmodule : usart_ctrl_properties
bind usart_ctrl usart_ctrl_properties u_props (.clk_i, .rst_i, .wb_i,
  .wb_ack_o, .wb_dat_o, .txck_pin_i, .txck_pin_o, .txck_pin_oe_o,
  .rxdt_pin_i, .rxdt_pin_o, .rxdt_pin_oe_o);

// [verification/usart_partner.sv]
// Far-side serial peer: async frame sender, async and sync frame catchers.
// Assumes the pad pins of usart_ctrl; the released clock pad input wanders.
`timescale 1ns/1ns
module usart_partner (
  input wire logic clk_i,
  input wire logic txck_pin_o,
  input wire logic txck_pin_oe_o,
  input wire logic rxdt_pin_o,
  input wire logic rxdt_pin_oe_o,
  output logic txck_pin_i,
  output logic rxdt_pin_i
);
  logic drv_ff = 1'b1;
  logic flip_ff = 1'b0;
  logic ck_ff = 1'b0;
  always @(posedge clk_i)
  begin
    flip_ff <= ~flip_ff;
    ck_ff <= txck_pin_o;
  end
  // Released clock pad wanders
  assign txck_pin_i = txck_pin_oe_o ? txck_pin_o : flip_ff;
  assign rxdt_pin_i = rxdt_pin_oe_o ? rxdt_pin_o : drv_ff;
  task automatic send(input logic [8:0] v, input int n, input int bt,
    input logic stp);
    for (int i = -1; i <= n; i++)
    begin
      @(posedge clk_i);
      drv_ff <= (i < 0) ? 1'b0 : ((i == n) ? stp : v[i]);
      repeat (bt - 1) @(posedge clk_i);
    end
    @(posedge clk_i);
    drv_ff <= 1'b1;
  endtask : send
  // Start bit length, then mid-bit samples up to stop
  task automatic aget(input int n, input int bt, output logic [9:0] v,
    output int lo);
    v = '0;
    lo = 0;
    do @(negedge clk_i); while (txck_pin_o !== 1'b0);
    while (txck_pin_o === 1'b0) @(negedge clk_i) lo++;
    repeat (bt / 2) @(negedge clk_i);
    for (int i = 0; i <= n; i++)
    begin
      v[i] = txck_pin_o;
      repeat (bt) @(negedge clk_i);
    end
  endtask : aget
  // Data taken at each rise of the device clock
  task automatic sget(output int per, output logic [9:0] v);
    int c;
    v = '0;
    per = 0;
    for (int i = 0; i < 8; i++)
    begin
      c = 0;
      do @(negedge clk_i) c++; while (!(txck_pin_o && !ck_ff));
      v[i] = rxdt_pin_o;
      per = c;
    end
  endtask : sget
endmodule : usart_partner
